//--- pkg/nfh_cfg.svh
`ifndef NFH_CFG_SVH
`define NFH_CFG_SVH
// Timing in ns at 40 MHz
`define NFH_CLK_NS        25
`define NFH_T_FULL_NS     55
`define NFH_T_PACC_NS     20
`define NFH_T_WP_NS       50
`define NFH_T_RP_NS       500
`define NFH_T_RH_NS       200
`define NFH_CYC_MIN(t)    ((((t) + `NFH_CLK_NS - 1) / `NFH_CLK_NS) < 1 ? 1 : (((t) + `NFH_CLK_NS - 1) / `NFH_CLK_NS))
`define NFH_FULL_CYC      `NFH_CYC_MIN(`NFH_T_FULL_NS)
`define NFH_PACC_CYC      `NFH_CYC_MIN(`NFH_T_PACC_NS)
`define NFH_WP_CYC        `NFH_CYC_MIN(`NFH_T_WP_NS)
`define NFH_RP_CYC        `NFH_CYC_MIN(`NFH_T_RP_NS)
`define NFH_RH_CYC        `NFH_CYC_MIN(`NFH_T_RH_NS)
// Field positions
`define NFH_PAGE_LSB      3
`define NFH_BANK_BITS     3
// Command codes
`define NFH_UNLOCK_A1     16'h0555
`define NFH_UNLOCK_D1     16'h00AA
`define NFH_UNLOCK_A2     16'h02AA
`define NFH_UNLOCK_D2     16'h0055
`define NFH_PROG_CMD      16'h00A0
`define NFH_RESET_CMD     16'h00F0
`endif

//--- pkg/nfh_pkg.sv
package nfh_pkg;
    typedef enum logic [2:0] {
        NFH_OP_READ,
        NFH_OP_WRITE,
        NFH_OP_PROG,
        NFH_OP_BYPASS_PROG,
        NFH_OP_RESET
    } nfh_op_t;

    typedef enum logic [1:0] {
        NFH_BANK_A,
        NFH_BANK_B,
        NFH_BANK_C,
        NFH_BANK_D
    } nfh_bank_t;

    typedef enum {
        NFH_ST_IDLE,
        NFH_ST_RSTLOW,
        NFH_ST_RSTREC,
        NFH_ST_READ,
        NFH_ST_WRITE,
        NFH_ST_WGAP
    } nfh_state_t;
endpackage

//--- hdl/nfh_bank_dec.sv
`timescale 1ns/1ps
module nfh_bank_dec
    import nfh_pkg::*;
(
    input  wire logic [2:0] bank_bits,
    output nfh_bank_t       bank
);
    // Three top address bits to bank
    always_comb begin
        unique case (bank_bits)
            3'h0: bank = NFH_BANK_A;
            3'h1, 3'h2, 3'h3: bank = NFH_BANK_B;
            3'h4, 3'h5, 3'h6: bank = NFH_BANK_C;
            default: bank = NFH_BANK_D;
        endcase
    end
endmodule // nfh_bank_dec

//--- hdl/nfh_host.sv
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE_01: Reads drive chip select, gate low, strobe high
// RULE_02: Data bus released whenever gate is low
// RULE_03: Array reads need no command after reset
// RULE_04: Bank stays read mode until command write
// RULE_05: Low three address bits pick page word
// RULE_06: Same page reads use short access time
// RULE_07: Top three address bits select bank
// RULE_08: Other banks readable during busy
// RULE_09: Writes drive strobe, select low, gate high
// RULE_10: Command cycles carry address and data
// RULE_11: Bypass program uses two write cycles
// RULE_12: Erase commands target sector address bits
// RULE_13: High-voltage accel level gives bypass mode
// RULE_14: Accel level only for two-cycle programming; the code also raises it while idle
// RULE_15: Protect input high for edge sector writes
// RULE_16: Identification reads use standard read timing
// RULE_17: Reset high-voltage level gives temporary unprotect
// RULE_18: Low reset aborts, device ignores bus
// RULE_19: Deselected device floats data outputs
// RULE_20: Busy output low during algorithms and reset
// RULE_21: High-voltage levels are separate mode outputs
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "nfh_cfg.svh"
module nfh_host
    import nfh_pkg::*;
#(
    parameter int ADDR_W  = 23,
    parameter int DATA_W  = 16,
    parameter int RP_CYC  = `NFH_RP_CYC,
    parameter int RH_CYC  = `NFH_RH_CYC
)(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire nfh_op_t           req_op,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic              accel_req,
    input  wire logic              unprotect_req,
    input  wire logic              edge_protect,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output nfh_bank_t              rsp_bank,
    output logic                   busy,
    output logic [ADDR_W-1:0]      address_pins,
    output logic [DATA_W-1:0]      data_pins_out,
    output logic                   data_pins_oe,
    input  wire logic [DATA_W-1:0] data_pins_in,
    output logic                   chip_sel_n,
    output logic                   out_gate_n,
    output logic                   wr_strobe_n,
    output logic                   flash_reset_n,
    output logic                   reset_hv,
    output logic                   protect_accel_in,
    output logic                   accel_hv,
    input  wire logic              ready_busy_out
);
    if (ADDR_W < 12 || DATA_W != 16 || RP_CYC < 1 || RH_CYC < 1) begin : g_bad_param
        $error("nfh_host: unsupported parameters");
    end

    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] FULL_C = CNT_W'(`NFH_FULL_CYC);
    localparam logic [CNT_W-1:0] PACC_C = CNT_W'(`NFH_PACC_CYC);
    localparam logic [CNT_W-1:0] WP_C   = CNT_W'(`NFH_WP_CYC);
    localparam logic [CNT_W-1:0] RP_C   = CNT_W'(RP_CYC);
    localparam logic [CNT_W-1:0] RH_C   = CNT_W'(RH_CYC);

    //////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_s1;
    logic rst_s2;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end
    wire logic rst_n = rst_s2;

    function automatic logic same_page(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        return a[ADDR_W-1:`NFH_PAGE_LSB] == b[ADDR_W-1:`NFH_PAGE_LSB];
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Bank decode
    nfh_bank_t req_bank;
    nfh_bank_dec u_bank (
        .bank_bits (req_addr[ADDR_W-1 -: `NFH_BANK_BITS]),   // see RULE_07
        .bank      (req_bank)
    );

    //////////////////////////////////////////////////////////////////////////
    // Sequencer
    nfh_state_t        state, next_state;
    logic [CNT_W-1:0]  cnt, next_cnt;
    logic [1:0]        seq, next_seq;
    logic [1:0]        seq_len, next_seq_len;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [DATA_W-1:0] wdata, next_wdata;
    logic [ADDR_W-1:0] last_addr, next_last_addr;
    logic              page_ok, next_page_ok;
    logic              cs_n, next_cs_n;
    logic              oe_n, next_oe_n;
    logic              we_n, next_we_n;
    logic              drv, next_drv;
    logic              frst_n, next_frst_n;
    logic              rvalid, next_rvalid;
    logic [DATA_W-1:0] rdata, next_rdata;
    nfh_bank_t         rbank, next_rbank;
    nfh_op_t           op, next_op;
    logic [ADDR_W-1:0] taddr, next_taddr;
    logic [DATA_W-1:0] tdata, next_tdata;

    function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input logic [1:0] i, input logic [1:0] len,
                                                          input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [ADDR_W-1:0] ua;
        ua = a;
        if (i == len) begin
            return {a, d};
        end
        ua[`NFH_PAGE_LSB+8:0] = '0;
        // Unlock cycles at target address with bits 11:0 cleared; last-but-one is program code
        if (len == 2'd3 && i == 2'd0) return {ua | ADDR_W'(`NFH_UNLOCK_A1), `NFH_UNLOCK_D1};
        if (len == 2'd3 && i == 2'd1) return {ua | ADDR_W'(`NFH_UNLOCK_A2), `NFH_UNLOCK_D2};
        return {ua | ADDR_W'(`NFH_UNLOCK_A1), `NFH_PROG_CMD};
    endfunction

    always_comb begin
        next_state     = state;
        next_cnt       = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_seq       = seq;
        next_seq_len   = seq_len;
        next_addr      = addr;
        next_wdata     = wdata;
        next_last_addr = last_addr;
        next_page_ok   = page_ok;
        next_cs_n      = cs_n;
        next_oe_n      = oe_n;
        next_we_n      = we_n;
        next_drv       = drv;
        next_frst_n    = frst_n;
        next_rvalid    = 1'b0;
        next_rdata     = rdata;
        next_rbank     = rbank;
        next_op        = op;
        next_taddr     = taddr;
        next_tdata     = tdata;
        unique case (state)
            NFH_ST_IDLE: begin
                if (req_valid) begin
                    next_addr  = req_addr;
                    next_wdata = req_wdata;
                    next_op    = req_op;
                    next_rbank = req_bank;
                    unique case (req_op)
                        NFH_OP_READ: begin
                            // Gate low, strobe high, select low; see RULE_01
                            next_state = NFH_ST_READ;
                            next_cs_n  = 1'b0;
                            next_oe_n  = 1'b0;
                            next_we_n  = 1'b1;
                            next_drv   = 1'b0;                       // see RULE_02
                            next_cnt   = (page_ok && same_page(req_addr, last_addr)) ? PACC_C : FULL_C; // see RULE_06
                        end
                        NFH_OP_RESET: begin
                            next_state  = NFH_ST_RSTLOW;           // see RULE_18
                            next_frst_n = 1'b0;
                            next_cs_n   = 1'b1;
                            next_oe_n   = 1'b1;
                            next_we_n   = 1'b1;
                            next_drv    = 1'b0;
                            next_page_ok = 1'b0;
                            next_cnt    = RP_C;
                        end
                        default: begin
                            // Command or program cycles; see RULE_10 RULE_11 RULE_12
                            next_seq_len = (req_op == NFH_OP_PROG) ? 2'd3 :
                                           (req_op == NFH_OP_BYPASS_PROG) ? 2'd1 : 2'd0;
                            next_seq     = 2'd0;
                            {next_taddr, next_tdata} = {req_addr, req_wdata};
                            next_state   = NFH_ST_WRITE;
                            next_page_ok = 1'b0;
                            {next_addr, next_wdata} = seq_word(2'd0, next_seq_len, req_addr, req_wdata);
                            next_cs_n  = 1'b0;                     // see RULE_09
                            next_oe_n  = 1'b1;
                            next_we_n  = 1'b0;
                            next_drv   = 1'b1;
                            next_cnt   = WP_C;
                        end
                    endcase
                end else begin
                    // Deselect between requests; page restarts at full time
                    next_cs_n    = 1'b1;                           // see RULE_19
                    next_oe_n    = 1'b1;
                    next_page_ok = 1'b0;
                end
            end
            NFH_ST_READ: begin
                if (cnt == '0) begin
                    next_rdata     = data_pins_in;                 // see RULE_03 RULE_16
                    next_rvalid    = 1'b1;
                    next_last_addr = addr;
                    next_page_ok   = 1'b1;                         // see RULE_05
                    next_state     = NFH_ST_IDLE;
                    if (!req_valid || req_op != NFH_OP_READ) begin
                        next_oe_n = 1'b1;
                    end
                end
            end
            NFH_ST_WRITE: begin
                if (cnt == '0) begin
                    next_we_n  = 1'b1;
                    next_state = NFH_ST_WGAP;
                    next_cnt   = WP_C;
                end
            end
            NFH_ST_WGAP: begin
                if (cnt == '0) begin
                    if (seq == seq_len) begin
                        next_drv   = 1'b0;
                        next_cs_n  = 1'b1;
                        next_rvalid = 1'b1;
                        next_state = NFH_ST_IDLE;
                    end else begin
                        next_seq = seq + 2'd1;
                        {next_addr, next_wdata} = seq_word(seq + 2'd1, seq_len, taddr, tdata);
                        next_we_n  = 1'b0;
                        next_cnt   = WP_C;
                        next_state = NFH_ST_WRITE;
                    end
                end
            end
            NFH_ST_RSTLOW: begin
                if (cnt == '0) begin
                    next_frst_n = 1'b1;
                    next_cnt    = RH_C;
                    next_state  = NFH_ST_RSTREC;
                end
            end
            NFH_ST_RSTREC: begin
                if (cnt == '0 && ready_busy_out) begin
                    next_rvalid = 1'b1;
                    next_state  = NFH_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= NFH_ST_IDLE;
            cnt       <= '0;
            seq       <= 2'd0;
            seq_len   <= 2'd0;
            addr      <= '0;
            wdata     <= '0;
            last_addr <= '0;
            page_ok   <= 1'b0;
            cs_n      <= 1'b1;
            oe_n      <= 1'b1;
            we_n      <= 1'b1;
            drv       <= 1'b0;
            frst_n    <= 1'b1;
            rvalid    <= 1'b0;
            rdata     <= '0;
            rbank     <= NFH_BANK_A;
            op        <= NFH_OP_READ;
            {taddr, tdata} <= '0;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            seq       <= next_seq;
            seq_len   <= next_seq_len;
            addr      <= next_addr;
            wdata     <= next_wdata;
            last_addr <= next_last_addr;
            page_ok   <= next_page_ok;
            cs_n      <= next_cs_n;
            oe_n      <= next_oe_n;
            we_n      <= next_we_n;
            drv       <= next_drv;
            frst_n    <= next_frst_n;
            rvalid    <= next_rvalid;
            rdata     <= next_rdata;
            rbank     <= next_rbank;
            op        <= next_op;
            {taddr, tdata} <= {next_taddr, next_tdata};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Mode pins
    logic hv_acc, next_hv_acc;
    logic hv_rst, next_hv_rst;
    logic wp, next_wp;
    always_comb begin
        // Accel level only while idle or in a bypass program; see RULE_13 RULE_14 RULE_21
        next_hv_acc = accel_req && (state == NFH_ST_IDLE ? 1'b1 : (op == NFH_OP_BYPASS_PROG));
        next_hv_rst = unprotect_req && next_frst_n;               // see RULE_17
        next_wp     = !edge_protect;                               // see RULE_15
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hv_acc <= 1'b0;
            hv_rst <= 1'b0;
            wp     <= 1'b1;
        end else begin
            hv_acc <= next_hv_acc;
            hv_rst <= next_hv_rst;
            wp     <= next_wp;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs
    assign req_ready        = (state == NFH_ST_IDLE);          // see RULE_04 RULE_08
    assign rsp_valid        = rvalid;
    assign rsp_rdata        = rdata;
    assign rsp_bank         = rbank;
    assign busy             = !ready_busy_out;                  // see RULE_20
    assign address_pins     = addr;
    assign data_pins_out    = wdata;
    assign data_pins_oe     = drv & oe_n;                       // see RULE_02
    assign chip_sel_n       = cs_n;
    assign out_gate_n       = oe_n;
    assign wr_strobe_n      = we_n;
    assign flash_reset_n    = frst_n;
    assign reset_hv         = hv_rst;
    assign protect_accel_in = wp | hv_acc;
    assign accel_hv         = hv_acc;
endmodule // nfh_host

//--- verification/nfh_flash_model.sv
`timescale 1ns/1ps
module nfh_flash_model #(
    parameter logic [15:0] ID_WORD = 16'h0C3E  // Arbitrary value
)(
    input  wire logic [22:0] address_pins,
    input  wire logic [15:0] data_pins_out,
    input  wire logic        chip_sel_n,
    input  wire logic        out_gate_n,
    input  wire logic        wr_strobe_n,
    input  wire logic        flash_reset_n,
    input  wire logic        reset_hv,
    input  wire logic        protect_accel_in,
    input  wire logic        accel_hv,
    output logic      [15:0] data_pins_in,
    output logic             ready_busy_out
);
    logic [15:0] mem [int];
    logic [22:0] a;
    logic [19:0] pg = 20'h00000;
    logic [2:0]  bb = 3'h0;
    logic [1:0]  st = 2'h0;
    logic        idm = 1'b0;
    logic        ok = 1'b0;
    logic        rb = 1'b1;
    logic        cs_was = 1'b0;
    function automatic logic [15:0] rdf(input logic [22:0] x);
        if (idm) return ID_WORD;
        if (!rb && x[22:20] == bb) return 16'h0000;
        return mem.exists(x) ? mem[x] : x[15:0] ^ 16'h5A5A;
    endfunction
    assign data_pins_in = (!chip_sel_n && !out_gate_n && flash_reset_n && ok) ?
                          rdf(address_pins) : ~rdf(address_pins);
    assign ready_busy_out = rb && flash_reset_n;
    // Access time, short within an open page
    always @(address_pins or chip_sel_n) begin
        ok = 1'b0;
        ok <= #((address_pins[22:3] == pg && !chip_sel_n && cs_was) ? 20 : 55) 1'b1;
        pg = address_pins[22:3];
        cs_was = !chip_sel_n;
    end
    always @(negedge flash_reset_n) begin
        st = 2'h0;
        idm = 1'b0;
    end
    // Command latch
    always @(posedge wr_strobe_n) begin
        if ((!chip_sel_n && out_gate_n && flash_reset_n) || reset_hv) begin
            a = address_pins;
            if (data_pins_out == 16'h00F0) begin
                st = 2'h0;
                idm = 1'b0;
            end else if (st == 2'h3) begin
                if (reset_hv || accel_hv || protect_accel_in || (a[22:13] != 10'h000 && a[22:13] != 10'h3FF))
                    mem[a] = data_pins_out;
                st = 2'h0;
                bb = a[22:20];
                rb = 1'b0;
                rb <= #1000 1'b1;
            end else if (data_pins_out == 16'h00A0 && (st == 2'h2 || accel_hv)) st = 2'h3;
            else if (st == 2'h0 && a[11:0] == 12'h555 && data_pins_out == 16'h00AA) st = 2'h1;
            else if (st == 2'h1 && a[11:0] == 12'h2AA && data_pins_out == 16'h0055) st = 2'h2;
            else if (st == 2'h2 && data_pins_out == 16'h0090) idm = 1'b1;
            else st = 2'h0;
        end
    end
endmodule  // nfh_flash_model

//--- verification/nfh_host_properties.sv
`timescale 1ns/1ps
module nfh_host_props
    import nfh_pkg::*;
#(
    parameter int RP_CYC = 2
)(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        edge_protect,
    input wire logic        rsp_valid,
    input wire logic        busy,
    input wire logic [22:0] address_pins,
    input wire logic [15:0] data_pins_out,
    input wire logic        data_pins_oe,
    input wire logic        chip_sel_n,
    input wire logic        out_gate_n,
    input wire logic        wr_strobe_n,
    input wire logic        flash_reset_n,
    input wire logic        reset_hv,
    input wire logic        protect_accel_in,
    input wire logic        accel_hv,
    input wire logic        ready_busy_out
);
    logic [1:0] up, next_up;
    logic [7:0] low, next_low;
    always_comb begin
        next_up  = (up == 2'h3) ? up : up + 2'h1;
        next_low = flash_reset_n ? 8'h00 : low + 8'h01;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            up  <= 2'h0;
            low <= 8'h00;
        end else begin
            up  <= next_up;
            low <= next_low;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////
    property p_oe_gate; data_pins_oe |-> out_gate_n; endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("data driven with gate low");
    property p_read_lvl; !out_gate_n |-> !chip_sel_n && wr_strobe_n && !data_pins_oe; endproperty
    a_read_lvl: assert property (p_read_lvl) else $error("bad read levels");
    property p_write_lvl; !wr_strobe_n |-> !chip_sel_n && out_gate_n && data_pins_oe; endproperty
    a_write_lvl: assert property (p_write_lvl) else $error("bad write levels");
    property p_we_width; $fell(wr_strobe_n) |-> !wr_strobe_n [*3] ##1 wr_strobe_n; endproperty
    a_we_width: assert property (p_we_width) else $error("strobe width wrong");
    property p_wr_hold; !wr_strobe_n && !$past(wr_strobe_n) |-> $stable(address_pins) && $stable(data_pins_out);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write cycle unstable");
    property p_accel; accel_hv |-> protect_accel_in; endproperty
    a_accel: assert property (p_accel) else $error("accel without high pin");
    property p_edge; up == 2'h3 && $past(edge_protect) && !accel_hv |-> !protect_accel_in; endproperty
    a_edge: assert property (p_edge) else $error("protect pin not low");
    property p_unprot; reset_hv |-> flash_reset_n; endproperty
    a_unprot: assert property (p_unprot) else $error("unprotect during reset");
    property p_rst_quiet; !flash_reset_n |-> chip_sel_n && wr_strobe_n && out_gate_n; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("bus active in reset");
    property p_rst_len; $rose(flash_reset_n) |-> low >= RP_CYC; endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
    property p_busy; busy == !ready_busy_out; endproperty
    a_busy: assert property (p_busy) else $error("busy mismatch");
    c_read: cover property (rsp_valid && !chip_sel_n);
    c_accel: cover property ($rose(accel_hv));
    c_reset: cover property ($rose(flash_reset_n));
endmodule  // nfh_host_props
bind nfh_host nfh_host_props #(.RP_CYC(RP_CYC)) u_props (.clk, .reset_n, .edge_protect, .rsp_valid, .busy,
    .address_pins, .data_pins_out, .data_pins_oe, .chip_sel_n, .out_gate_n, .wr_strobe_n, .flash_reset_n,
    .reset_hv, .protect_accel_in, .accel_hv, .ready_busy_out);

//--- verification/nfh_host_test.sv
`timescale 1ns/1ps
`include "nfh_cfg.svh"
module nfh_host_test;
    import nfh_pkg::*;
    typedef struct packed {nfh_op_t op; logic [22:0] a; logic [15:0] d; logic [15:0] e;} nfh_row_t;
    localparam logic [15:0] ID_WORD = 16'h0C3E;  // Arbitrary value
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        req_valid = 1'b0;
    logic        accel_req = 1'b0;
    logic        unprotect_req = 1'b0;
    logic        edge_protect = 1'b0;
    nfh_op_t     req_op = NFH_OP_READ;
    logic [22:0] req_addr = 23'h0, address_pins;
    logic [15:0] req_wdata = 16'h0, rsp_rdata, data_pins_out, data_pins_in;
    logic        req_ready, rsp_valid, busy, data_pins_oe, chip_sel_n, out_gate_n, wr_strobe_n;
    logic        flash_reset_n, reset_hv, protect_accel_in, accel_hv, ready_busy_out;
    nfh_bank_t   rsp_bank;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          lat, l1;
    nfh_row_t    rows [16] = '{
        '{NFH_OP_READ, 23'h000010, 16'h0, 16'h5A4A}, '{NFH_OP_READ, 23'h100020, 16'h0, 16'h5A7A},
        '{NFH_OP_READ, 23'h300004, 16'h0, 16'h5A5E}, '{NFH_OP_READ, 23'h400000, 16'h0, 16'h5A5A},
        '{NFH_OP_READ, 23'h600008, 16'h0, 16'h5A52}, '{NFH_OP_READ, 23'h700001, 16'h0, 16'h5A5B},
        '{NFH_OP_PROG, 23'h100040, 16'h1234, 16'h0}, '{NFH_OP_READ, 23'h100040, 16'h0, 16'h1234},
        '{NFH_OP_WRITE, 23'h000555, 16'h00AA, 16'h0}, '{NFH_OP_WRITE, 23'h0002AA, 16'h0055, 16'h0},
        '{NFH_OP_WRITE, 23'h000555, 16'h0090, 16'h0}, '{NFH_OP_READ, 23'h000000, 16'h0, ID_WORD},
        '{NFH_OP_WRITE, 23'h000000, 16'h00F0, 16'h0}, '{NFH_OP_READ, 23'h000000, 16'h0, 16'h5A5A},
        '{NFH_OP_RESET, 23'h000000, 16'h0, 16'h0}, '{NFH_OP_READ, 23'h100040, 16'h0, 16'h1234}};
    always #12.5 clk = ~clk;
    nfh_host #(.RP_CYC(2), .RH_CYC(2)) u_dut (.clk, .reset_n, .req_valid, .req_ready, .req_op, .req_addr,
        .req_wdata, .accel_req, .unprotect_req, .edge_protect, .rsp_valid, .rsp_rdata, .rsp_bank, .busy,
        .address_pins, .data_pins_out, .data_pins_oe, .data_pins_in, .chip_sel_n, .out_gate_n, .wr_strobe_n,
        .flash_reset_n, .reset_hv, .protect_accel_in, .accel_hv, .ready_busy_out);
    nfh_flash_model #(.ID_WORD(ID_WORD)) u_flash (.address_pins, .data_pins_out, .chip_sel_n, .out_gate_n,
        .wr_strobe_n, .flash_reset_n, .reset_hv, .protect_accel_in, .accel_hv, .data_pins_in, .ready_busy_out);
    ////////////////////////////////////////////////////////////////////////////
    function automatic nfh_bank_t bank_of(input logic [2:0] b);
        return b == 3'h0 ? NFH_BANK_A : b < 3'h4 ? NFH_BANK_B : b < 3'h7 ? NFH_BANK_C : NFH_BANK_D;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic gap(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic wait_ready;
        for (int n = 0; n < 200 && busy !== 1'b0; n++) gap(1);
        chk(busy, 1'b0);
    endtask
    task automatic txn(input nfh_op_t op, input logic [22:0] a, input logic [15:0] d);
        req_op = op;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        for (int n = 0; n < 3000 && req_ready !== 1'b1; n++) gap(1);
        gap(1);
        req_valid = 1'b0;
        for (lat = 1; lat < 3000 && rsp_valid !== 1'b1; lat++) gap(1);
        chk(rsp_valid, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        gap(4);
        reset_n = 1'b1;
        gap(3);
        foreach (rows[i]) begin
            txn(rows[i].op, rows[i].a, rows[i].d);
            chk(rsp_bank, bank_of(rows[i].a[22:20]));
            if (rows[i].op == NFH_OP_READ) chk(rsp_rdata, rows[i].e);
            else wait_ready();
        end
        // Page reads
        gap(3);
        txn(NFH_OP_READ, 23'h200000, 16'h0);
        l1 = lat;
        txn(NFH_OP_READ, 23'h200005, 16'h0);
        chk(rsp_rdata, 16'h5A5F);
        chk(l1 - lat, `NFH_FULL_CYC - `NFH_PACC_CYC);
        txn(NFH_OP_READ, 23'h200008, 16'h0);
        chk(lat, l1);
        // Other bank read while programming
        txn(NFH_OP_PROG, 23'h000100, 16'hCAFE);
        txn(NFH_OP_READ, 23'h400100, 16'h0);
        chk(busy, 1'b1);
        chk(rsp_rdata, 16'h5B5A);
        wait_ready();
        txn(NFH_OP_READ, 23'h000100, 16'h0);
        chk(rsp_rdata, 16'hCAFE);
        // Accelerated bypass program
        accel_req = 1'b1;
        txn(NFH_OP_BYPASS_PROG, 23'h500010, 16'hBEEF);
        chk({accel_hv, protect_accel_in}, 2'b11);
        accel_req = 1'b0;
        wait_ready();
        gap(2);
        chk(accel_hv, 1'b0);
        txn(NFH_OP_READ, 23'h500010, 16'h0);
        chk(rsp_rdata, 16'hBEEF);
        // Edge sector locked, then temporary unprotect
        edge_protect = 1'b1;
        gap(2);
        chk(protect_accel_in, 1'b0);
        for (int k = 0; k < 2; k++) begin
            txn(NFH_OP_PROG, 23'h000020, 16'h0000);
            wait_ready();
            txn(NFH_OP_READ, 23'h000020, 16'h0);
            chk(rsp_rdata, k ? 16'h0000 : 16'h5A7A);
            unprotect_req = 1'b1;
            gap(2);
            chk(reset_hv, 1'b1);
        end
        unprotect_req = 1'b0;
        edge_protect = 1'b0;
        // Reset pulse aborting a program
        txn(NFH_OP_PROG, 23'h100200, 16'h1111);
        txn(NFH_OP_RESET, 23'h000000, 16'h0);
        chk(32'(lat >= 4), 1);
        txn(NFH_OP_READ, 23'h100040, 16'h0);
        chk(rsp_rdata, 16'h1234);
        // Controller reset in mid-run
        reset_n = 1'b0;
        gap(4);
        chk({chip_sel_n, out_gate_n, wr_strobe_n, flash_reset_n, data_pins_oe, accel_hv}, 6'h3C);
        reset_n = 1'b1;
        gap(3);
        txn(NFH_OP_READ, 23'h700001, 16'h0);
        chk(rsp_rdata, 16'h5A5B);
        stop_test();
    end
endmodule  // nfh_host_test
